// *** include/dfc_map.vh ***
// Constants of the decimation and calibration datapath.
// Assumes inclusion by bare name from the rtl files; definitions only.
`ifndef DFC_MAP_VH
`define DFC_MAP_VH

// Ratio select 0 gives 2^7 = 128; each step doubles the ratio
`define DFC_RATIO_BASE_LOG 7
// Highest select that the third-order stage runs at directly (1024)
`define DFC_S3_MAX_SEL 3'h3
// Longest overall ratio log2 (16384)
`define DFC_RATIO_MAX_LOG 14
// Result and coefficient width
`define DFC_OUT_W 24
// Third-order stage accumulator width
`define DFC_CIC_W 32
// Coefficient reset values: no offset, unity gain
`define DFC_OFFSET_RESET 24'h000000
`define DFC_GAIN_RESET 24'h800000
// Gain has 23 fraction bits
`define DFC_GAIN_FRAC 23
// Filter results are scaled so that full scale is 2^23
`define DFC_RESULT_FRAC 23
// Saturation limits of the 24-bit two's complement result
`define DFC_POS_FULL 24'h7FFFFF
`define DFC_NEG_FULL 24'h800000
// Coefficient write select codes
`define DFC_SEL_OFS_UPPER 2'h0
`define DFC_SEL_OFS_LOWER 2'h1
`define DFC_SEL_GAIN_UPPER 2'h2
`define DFC_SEL_GAIN_LOWER 2'h3
// Upper register holds coefficient bits 23:8, lower holds bits 7:0
`define DFC_UPPER_LSB 8
// Number of results taken from the fast-settling path after reset
`define DFC_FAST_CONVERSIONS 2'h2

`endif

// *** rtl/dfc_fifo.v ***
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes one clock; DEPTH is a power of two equal to 2^AW.
`timescale 1ns/1ps
module dfc_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg full;
  reg empty;
  wire push = in_valid & ~full;
  wire pop = out_valid & out_ready;
  wire [AW:0] next_count = (push & ~pop) ? count + 1'b1 :
                           (pop & ~push) ? count - 1'b1 : count;

  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr];

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      full <= 1'b0;
      empty <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      full <= (next_count == DEPTH[AW:0]);
      empty <= (next_count == {(AW+1){1'b0}});
    end
  end
endmodule

// *** rtl/dfc_filter.v ***
// Multi-channel decimation filter with offset and gain correction.
// Assumes modulator bits synchronous to clk, one per channel, sampled at clk/2.
`timescale 1ns/1ps
`include "dfc_map.vh"
module dfc_filter #(
  parameter NCH = 4,
  parameter CHW = 2,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Modulator streams and configuration
  input wire [NCH-1:0] mod_bits,
  input wire [2:0] decimation_ratio_select,
  input wire [NCH-1:0] channel_enable,
  input wire [NCH-1:0] channel_restart,
  input wire resync,
  // Coefficient access
  input wire coeff_wr,
  input wire [CHW-1:0] coeff_ch,
  input wire [1:0] coeff_sel,
  input wire [15:0] coeff_wdata,
  output reg [15:0] coeff_rdata,
  // Results towards the host
  output wire result_valid,
  input wire result_ready,
  output wire [`DFC_OUT_W-1:0] result_data,
  output wire [CHW-1:0] result_channel,
  output reg sample_ready_n,
  // Status
  output reg fast_path_active,
  output reg overrun,
  input wire overrun_clear
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CORR = 1'b1;
  localparam OW = `DFC_OUT_W;
  localparam CW = `DFC_CIC_W;
  localparam RW = `DFC_RATIO_MAX_LOG + 1;

  function [OW-1:0] sat50;
    input signed [49:0] v;
    begin
      if (v > $signed({{26{1'b0}}, `DFC_POS_FULL}))
        sat50 = `DFC_POS_FULL;
      else if (v < $signed({{26{1'b1}}, `DFC_NEG_FULL}))
        sat50 = `DFC_NEG_FULL;
      else
        sat50 = v[OW-1:0];
    end
  endfunction

  // Modulator rate and period timing
  reg mod_phase;
  reg [2:0] ratio_q;
  reg [RW-1:0] mod_count;
  reg s3_dump;
  reg period_dump;
  reg state;
  reg [CHW-1:0] ch_idx;
  reg [1:0] conv_done;
  reg [OW-1:0] offset_coefficient [0:NCH-1];
  reg [OW-1:0] gain_coefficient [0:NCH-1];
  wire mod_tick = mod_phase;
  wire ratio_changed = (ratio_q != decimation_ratio_select);
  wire long_ratio = (ratio_q > `DFC_S3_MAX_SEL);
  wire [2:0] s3_sel = long_ratio ? `DFC_S3_MAX_SEL : ratio_q;
  wire [RW-1:0] one_w = {{(RW-1){1'b0}}, 1'b1};
  wire [RW-1:0] overall_len = one_w << (ratio_q + `DFC_RATIO_BASE_LOG);
  wire [RW-1:0] s3_len = one_w << (s3_sel + `DFC_RATIO_BASE_LOG);
  wire [RW-1:0] count_inc = mod_count + one_w;
  wire s3_end = ((count_inc & (s3_len - one_w)) == {RW{1'b0}});
  wire period_end = (count_inc == overall_len);
  wire busy = (state == ST_CORR);
  wire accept = period_dump & ~busy;
  wire use_fast = (conv_done < `DFC_FAST_CONVERSIONS);
  // Full scale of the third-order sum is N^3 = 2^(3*log2 N)
  wire [31:0] s3_cube_full = 3 * (s3_sel + `DFC_RATIO_BASE_LOG);
  wire [31:0] s3_shift_full = 3 * s3_sel;
  // Fast sum spans N, so a shift by 23 - log2 N brings its full scale to 2^23
  wire [31:0] fast_shift_full = `DFC_RESULT_FRAC - `DFC_RATIO_BASE_LOG - ratio_q;
  wire [5:0] s3_cube_log = s3_cube_full[5:0];
  wire [3:0] s3_shift = s3_shift_full[3:0];
  wire [4:0] fast_shift = fast_shift_full[4:0];
  wire [2:0] s1_shift = ratio_q - `DFC_S3_MAX_SEL;
  wire [33:0] s3_full = 34'h1 << s3_cube_log;
  wire [NCH*OW-1:0] raw_bus;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mod_phase <= 1'b0;
      ratio_q <= 3'h0;
      mod_count <= {RW{1'b0}};
      s3_dump <= 1'b0;
      period_dump <= 1'b0;
    end else begin
      mod_phase <= ~mod_phase;
      ratio_q <= decimation_ratio_select;
      // Dumps land on the cycle after a tick, so they never meet a tick
      s3_dump <= mod_tick & s3_end & ~ratio_changed & ~resync;
      period_dump <= mod_tick & period_end & ~ratio_changed & ~resync;
      if (ratio_changed | resync) begin
        mod_count <= {RW{1'b0}};
      end else if (mod_tick) begin
        mod_count <= period_end ? {RW{1'b0}} : count_inc;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      reg [CW-1:0] int1;
      reg [CW-1:0] int2;
      reg [CW-1:0] int3;
      reg [CW-1:0] dly1;
      reg [CW-1:0] dly2;
      reg [CW-1:0] dly3;
      reg signed [27:0] avg_acc;
      reg [RW-1:0] ones;
      reg [OW-1:0] raw;
      wire restart = ~channel_enable[g] | channel_restart[g] | resync | ratio_changed;
      // Integrators at the modulator rate, combs at the decimated rate
      wire [CW-1:0] comb1 = int3 - dly1;
      wire [CW-1:0] comb2 = comb1 - dly2;
      wire [CW-1:0] comb3 = comb2 - dly3;
      wire signed [33:0] s3_ctr = $signed({1'b0, comb3, 1'b0}) - $signed(s3_full);
      wire signed [33:0] s3_scaled = (s3_ctr <<< 2) >>> s3_shift;
      wire [OW-1:0] s3_out = sat50({{16{s3_scaled[33]}}, s3_scaled});
      wire signed [27:0] avg_sum = avg_acc + {{4{s3_out[OW-1]}}, s3_out};
      wire signed [27:0] avg_out = avg_sum >>> s1_shift;
      wire signed [33:0] fast_ctr = $signed({{18{1'b0}}, ones, 1'b0})
                                    - $signed({{19{1'b0}}, overall_len});
      wire signed [33:0] fast_scaled = fast_ctr <<< fast_shift;
      wire [OW-1:0] fast_out = sat50({{16{fast_scaled[33]}}, fast_scaled});
      wire [OW-1:0] s1_out = sat50({{22{avg_out[27]}}, avg_out});

      assign raw_bus[g*OW +: OW] = raw;

      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          int1 <= {CW{1'b0}};
          int2 <= {CW{1'b0}};
          int3 <= {CW{1'b0}};
          dly1 <= {CW{1'b0}};
          dly2 <= {CW{1'b0}};
          dly3 <= {CW{1'b0}};
          avg_acc <= 28'h0000000;
          ones <= {RW{1'b0}};
          raw <= {OW{1'b0}};
        end else if (restart) begin
          // Clearing all history makes the channel settle afresh
          int1 <= {CW{1'b0}};
          int2 <= {CW{1'b0}};
          int3 <= {CW{1'b0}};
          dly1 <= {CW{1'b0}};
          dly2 <= {CW{1'b0}};
          dly3 <= {CW{1'b0}};
          avg_acc <= 28'h0000000;
          ones <= {RW{1'b0}};
        end else begin
          if (mod_tick) begin
            int1 <= int1 + {{(CW-1){1'b0}}, mod_bits[g]};
            int2 <= int2 + int1;
            int3 <= int3 + int2;
            ones <= ones + {{(RW-1){1'b0}}, mod_bits[g]};
          end
          if (s3_dump) begin
            dly1 <= int3;
            dly2 <= comb1;
            dly3 <= comb2;
            avg_acc <= period_dump ? 28'h0000000 : avg_sum;
          end
          if (period_dump) begin
            ones <= {RW{1'b0}};
          end
          // Unsettled data is passed on like any other
          if (accept) begin
            raw <= use_fast ? fast_out :
                   long_ratio ? s1_out : s3_out;
          end
        end
      end
    end
  endgenerate

  // Correction of the channel being sequenced
  wire [OW-1:0] cur_raw = raw_bus[ch_idx*OW +: OW];
  wire [OW-1:0] cur_ofs = offset_coefficient[ch_idx];
  wire [OW-1:0] cur_gain = gain_coefficient[ch_idx];
  wire signed [24:0] diff = $signed({cur_raw[OW-1], cur_raw})
                            - $signed({cur_ofs[OW-1], cur_ofs});
  wire signed [49:0] prod = diff * $signed({1'b0, cur_gain});
  wire signed [49:0] prod_scaled = prod >>> `DFC_GAIN_FRAC;
  wire [OW-1:0] corrected = sat50(prod_scaled);
  wire fifo_in_ready;
  wire push = busy & fifo_in_ready;
  wire [31:0] last_full = NCH - 1;
  wire last_ch = (ch_idx == last_full[CHW-1:0]);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      ch_idx <= {CHW{1'b0}};
      conv_done <= 2'h0;
      sample_ready_n <= 1'b1;
      fast_path_active <= 1'b1;
      overrun <= 1'b0;
    end else begin
      sample_ready_n <= 1'b1;
      fast_path_active <= use_fast;
      // A new period while still draining is dropped; set beats clear
      if (period_dump & busy) begin
        overrun <= 1'b1;
      end else if (overrun_clear) begin
        overrun <= 1'b0;
      end
      if (accept & use_fast) begin
        conv_done <= conv_done + 2'h1;
      end
      case (state)
        ST_IDLE: begin
          ch_idx <= {CHW{1'b0}};
          if (accept) begin
            state <= ST_CORR;
          end
        end
        ST_CORR: begin
          if (push) begin
            ch_idx <= ch_idx + 1'b1;
            if (last_ch) begin
              state <= ST_IDLE;
              sample_ready_n <= 1'b0;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Coefficient store, split into upper and lower parts
  integer i;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < NCH; i = i + 1) begin
        offset_coefficient[i] <= `DFC_OFFSET_RESET;
        gain_coefficient[i] <= `DFC_GAIN_RESET;
      end
      coeff_rdata <= 16'h0000;
    end else begin
      if (coeff_wr) begin
        case (coeff_sel)
          `DFC_SEL_OFS_UPPER: begin
            offset_coefficient[coeff_ch][OW-1:`DFC_UPPER_LSB] <= coeff_wdata;
          end
          `DFC_SEL_OFS_LOWER: begin
            offset_coefficient[coeff_ch][`DFC_UPPER_LSB-1:0] <= coeff_wdata[7:0];
          end
          `DFC_SEL_GAIN_UPPER: begin
            gain_coefficient[coeff_ch][OW-1:`DFC_UPPER_LSB] <= coeff_wdata;
          end
          `DFC_SEL_GAIN_LOWER: begin
            gain_coefficient[coeff_ch][`DFC_UPPER_LSB-1:0] <= coeff_wdata[7:0];
          end
          default: begin
          end
        endcase
      end
      case (coeff_sel)
        `DFC_SEL_OFS_UPPER: coeff_rdata <= offset_coefficient[coeff_ch][OW-1:`DFC_UPPER_LSB];
        `DFC_SEL_OFS_LOWER: coeff_rdata <= {8'h00, offset_coefficient[coeff_ch][7:0]};
        `DFC_SEL_GAIN_UPPER: coeff_rdata <= gain_coefficient[coeff_ch][OW-1:`DFC_UPPER_LSB];
        default: coeff_rdata <= {8'h00, gain_coefficient[coeff_ch][7:0]};
      endcase
    end
  end

  // Result buffer; a stalled host holds off the sequencer
  dfc_fifo #(
    .WIDTH(OW + CHW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(busy),
    .in_ready(fifo_in_ready),
    .in_data({ch_idx, corrected}),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data({result_channel, result_data})
  );
endmodule

// *** testbench/dfc_props.sv ***
// Checker of the filter's result, status and coefficient ports.
// Assumes one clock domain and the port set of dfc_filter.
`timescale 1ns/1ps
module dfc_props #(
  parameter CHW = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Coefficient port
  input wire logic coeff_wr,
  input wire logic [CHW-1:0] coeff_ch,
  input wire logic [1:0] coeff_sel,
  input wire logic [15:0] coeff_wdata,
  input wire logic [15:0] coeff_rdata,
  // Results and status
  input wire logic result_valid,
  input wire logic result_ready,
  input wire logic [23:0] result_data,
  input wire logic [CHW-1:0] result_channel,
  input wire logic sample_ready_n,
  input wire logic fast_path_active,
  input wire logic overrun
);
  // Ready pulses since reset, held at three so it cannot wrap
  logic [1:0] n_rdy;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) n_rdy <= 2'h0;
    else if (!sample_ready_n && n_rdy != 2'h3) n_rdy <= n_rdy + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  reset_state_a:
  assert property ($rose(resetn) |-> fast_path_active && sample_ready_n && !result_valid
    && !overrun) else $error("state after reset wrong");
  fast_first_a:
  assert property (n_rdy == 2'h0 |-> fast_path_active) else $error("fast path off early");
  fast_end_a:
  assert property (n_rdy == 2'h3 |-> !fast_path_active) else $error("fast path still on");
  fast_stay_a:
  assert property (!fast_path_active |=> !fast_path_active) else $error("fast path back on");
  ready_pulse_a:
  assert property (!sample_ready_n |=> sample_ready_n) else $error("ready pulse too long");
  lower_zero_a:
  assert property (coeff_sel[0] |=> coeff_rdata[15:8] == 8'h00)
    else $error("lower part not zero extended");
  readback_a:
  assert property (coeff_wr && !coeff_sel[0] ##1 (!coeff_wr && $stable(coeff_sel)
    && $stable(coeff_ch)) [*2] |=> coeff_rdata == $past(coeff_wdata, 3))
    else $error("upper part readback wrong");
  result_hold_a:
  assert property (result_valid && !result_ready |=> result_valid && $stable(result_data)
    && $stable(result_channel)) else $error("result changed before pop");
  cover property ($fell(fast_path_active));
  cover property ($fell(sample_ready_n));
  cover property (result_valid && !result_ready);
  cover property ($rose(overrun));
endmodule
bind dfc_filter dfc_props #(.CHW(CHW)) dfc_props_i (.clk(clk), .resetn(resetn),
  .coeff_wr(coeff_wr), .coeff_ch(coeff_ch), .coeff_sel(coeff_sel),
  .coeff_wdata(coeff_wdata), .coeff_rdata(coeff_rdata), .result_valid(result_valid),
  .result_ready(result_ready), .result_data(result_data), .result_channel(result_channel),
  .sample_ready_n(sample_ready_n), .fast_path_active(fast_path_active), .overrun(overrun));

// *** testbench/dfc_host.sv ***
// Host model: pops results and keeps the latest one of each channel.
// Assumes a pop on each rising edge with valid and ready both high.
`timescale 1ns/1ps
module dfc_host (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Result stream
  input wire logic result_valid,
  output logic result_ready,
  input wire logic [23:0] result_data,
  input wire logic [1:0] result_channel,
  // Bench control and view
  input wire logic stall,
  output logic [23:0] latest [4],
  output int n_pop
);
  // Ready moves only after an edge, so a stall never cuts a pop in half
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_ready <= 1'b0;
      n_pop <= 0;
    end else begin
      result_ready <= !stall;
      if (result_valid && result_ready) begin
        latest[result_channel] <= result_data;
        n_pop <= n_pop + 1;
      end
    end
  end
endmodule

// *** testbench/dfc_filter_tb.sv ***
// Testbench of the filter: reset, coefficients, corrected results, ratios, buffering.
// Assumes dfc_filter, dfc_host and the checker are compiled before it.
`timescale 1ns/1ps
`include "dfc_map.vh"
module dfc_filter_tb;
  logic clk, resetn, coeff_wr, result_valid, sample_ready_n, fast_path_active, overrun;
  logic overrun_clear, stall, alt, ph, result_ready;
  logic resync;
  logic [3:0] chan_en, chan_rst;
  logic [3:0] mod_bits;
  logic [2:0] decimation_ratio_select;
  logic [1:0] coeff_ch, coeff_sel, result_channel;
  logic [15:0] coeff_wdata, coeff_rdata;
  logic [23:0] result_data;
  logic [23:0] latest [4];
  int n_pop;
  int n_fail = 0;
  int total_checks = 0;
  dfc_filter dfc_filter_i (.clk(clk), .resetn(resetn), .mod_bits(mod_bits),
    .decimation_ratio_select(decimation_ratio_select), .channel_enable(chan_en),
    .channel_restart(chan_rst), .resync(resync), .coeff_wr(coeff_wr), .coeff_ch(coeff_ch),
    .coeff_sel(coeff_sel), .coeff_wdata(coeff_wdata), .coeff_rdata(coeff_rdata),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
    .result_channel(result_channel), .sample_ready_n(sample_ready_n),
    .fast_path_active(fast_path_active), .overrun(overrun), .overrun_clear(overrun_clear));
  dfc_host dfc_host_i (.clk(clk), .resetn(resetn), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data), .result_channel(result_channel),
    .stall(stall), .latest(latest), .n_pop(n_pop));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Channel 0 sees all ones; the others a half density that alternates every tick
  initial begin
    ph = 1'b0;
    alt = 1'b0;
    mod_bits = 4'h1;
  end
  always @(negedge clk) begin
    ph <= !ph;
    if (ph) alt <= !alt;
    mod_bits <= {alt, alt, alt, 1'b1};
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("Checks made %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_rdy(output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (sample_ready_n !== 1'b0 && cyc < 40000);
    if (cyc >= 40000) begin
      n_fail++;
      complete_run;
    end
  endtask
  task automatic wr(input logic [1:0] ch, input logic [1:0] sel, input logic [15:0] d);
    coeff_ch = ch;
    coeff_sel = sel;
    coeff_wdata = d;
    coeff_wr = 1'b1;
    @(negedge clk);
    coeff_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic set24(input logic [1:0] ch, input logic [1:0] hi, input logic [23:0] v);
    wr(ch, hi, v[23:8]);
    wr(ch, hi + 2'h1, {8'h00, v[7:0]});
  endtask
  task automatic rd(input logic [1:0] ch, input logic [1:0] hi, output logic [23:0] v);
    coeff_ch = ch;
    coeff_sel = hi;
    repeat (2) @(negedge clk);
    v[23:8] = coeff_rdata;
    coeff_sel = hi + 2'h1;
    repeat (2) @(negedge clk);
    v[7:0] = coeff_rdata[7:0];
  endtask
  task automatic do_reset;
    logic [23:0] v;
    resetn = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    check("fast path", {23'h0, fast_path_active}, 24'h1);
    check("ready idle", {23'h0, sample_ready_n}, 24'h1);
    for (int c = 0; c < 4; c++) begin
      rd(c[1:0], 2'h0, v);
      check("offset default", v, `DFC_OFFSET_RESET);
      rd(c[1:0], 2'h2, v);
      check("gain default", v, `DFC_GAIN_RESET);
    end
  endtask
  task automatic t_coeff;
    logic [23:0] v;
    for (int c = 0; c < 4; c++) begin
      set24(c[1:0], 2'h0, 24'h123450 + 24'(c));
      set24(c[1:0], 2'h2, 24'hA00000 + 24'(c));
    end
    for (int c = 0; c < 4; c++) begin
      rd(c[1:0], 2'h0, v);
      check("offset readback", v, 24'h123450 + 24'(c));
      rd(c[1:0], 2'h2, v);
      check("gain readback", v, 24'hA00000 + 24'(c));
    end
  endtask
  task automatic t_conv;
    int cyc;
    set24(2'h0, 2'h2, 24'hFFFFFF);
    set24(2'h1, 2'h0, 24'h000100);
    set24(2'h2, 2'h0, 24'hFFFE00);
    set24(2'h2, 2'h2, 24'h400000);
    set24(2'h3, 2'h2, 24'h000000);
    wait_rdy(cyc);
    repeat (8) @(negedge clk);
    // The first result is the fast path's: all ones gives full scale there too
    check("fast still on", {23'h0, fast_path_active}, 24'h1);
    check("fast ch0", latest[0], `DFC_POS_FULL);
    check("fast ch1", latest[1], 24'hFFFF00);
    repeat (5) wait_rdy(cyc);
    repeat (8) @(negedge clk);
    check("fast path", {23'h0, fast_path_active}, 24'h0);
    check("ch0 saturated", latest[0], `DFC_POS_FULL);
    check("ch1 offset", latest[1], 24'hFFFF00);
    check("ch2 offset then gain", latest[2], 24'h000100);
    check("ch3 zero gain", latest[3], 24'h000000);
  endtask
  task automatic t_ratio;
    int cyc;
    for (int s = 0; s < 5; s++) begin
      decimation_ratio_select = s[2:0];
      repeat (3) wait_rdy(cyc);
      check("period clocks", 24'(cyc), 24'(256 << s));
    end
    wait_rdy(cyc);
    repeat (8) @(negedge clk);
    check("long ratio ch1", latest[1], 24'hFFFF00);
  endtask
  task automatic t_fill;
    int cyc;
    int n0;
    decimation_ratio_select = 3'h0;
    stall = 1'b1;
    cyc = 0;
    while (overrun !== 1'b1 && cyc < 5000) begin
      @(negedge clk);
      cyc++;
    end
    check("overrun", {23'h0, overrun}, 24'h1);
    check("held results", {23'h0, result_valid}, 24'h1);
    n0 = n_pop;
    stall = 1'b0;
    cyc = 0;
    while (result_valid !== 1'b0 && cyc < 200) begin
      @(negedge clk);
      cyc++;
    end
    check("drained", {23'h0, result_valid}, 24'h0);
    check("popped all", {23'h0, n_pop - n0 >= 16}, 24'h1);
    overrun_clear = 1'b1;
    @(negedge clk);
    overrun_clear = 1'b0;
    check("overrun cleared", {23'h0, overrun}, 24'h0);
  endtask
  // Restart channel 0 by re-enable (0), restart strobe (1) or resync (2)
  task automatic t_restart(input int how);
    int cyc;
    int tot;
    if (how == 0) chan_en = 4'hE;
    else if (how == 1) chan_rst = 4'h1;
    else resync = 1'b1;
    @(negedge clk);
    chan_en = 4'hF;
    chan_rst = 4'h0;
    resync = 1'b0;
    wait_rdy(tot);
    repeat (8) @(negedge clk);
    tot += 9;
    // Cleared history gives a partial sum far below mid scale, doubled by gain
    check("restart ch0", latest[0], `DFC_NEG_FULL);
    if (how != 2) check("other ch kept", latest[1], 24'hFFFF00);
    // Settling at ratio 128 is 432 modulator periods of two clocks each
    while (tot < 2 * 432) begin
      wait_rdy(cyc);
      tot += cyc;
    end
    repeat (8) @(negedge clk);
    check("settled ch0", latest[0], `DFC_POS_FULL);
    check("settled ch1", latest[1], 24'hFFFF00);
  endtask
  initial begin
    resetn = 1'b0;
    coeff_wr = 1'b0;
    coeff_ch = 2'h0;
    coeff_sel = 2'h0;
    coeff_wdata = 16'h0000;
    overrun_clear = 1'b0;
    stall = 1'b0;
    decimation_ratio_select = 3'h0;
    chan_en = 4'hF;
    chan_rst = 4'h0;
    resync = 1'b0;
    do_reset;
    t_coeff;
    do_reset;
    t_conv;
    t_ratio;
    t_fill;
    t_restart(0);
    t_restart(1);
    t_restart(2);
    complete_run;
  end
  initial begin
    #6000000;
    n_fail++;
    complete_run;
  end
endmodule
